// [sfrb_bank.sv]
// Bank-zero special function register bank with dual reset behaviour
//
// Behaviour
// - Unimplemented locations and bits read as zero.
// - Common registers decode at the same offset whatever the bank bits.
// - Upper PC bits are reached only through a 5-bit buffer fed to PC 12:8.
// - Power-on/brown-out and pin/watchdog resets give separate reset values.
// - Port writes load the output latch while port reads return the pin levels.
`timescale 1ns/100ps
`include "sfrb_defs.svh"

module sfrb_bank (
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 por_in,
    input  wire logic                 other_rst_in,
    input  wire sfrb_pkg::sfrb_access_t acc_in,
    input  wire sfrb_pkg::sfrb_ports_t  pins_in,
    input  wire logic [8:0]           indirect_rdata_in,
    input  wire logic [7:0]           pc_low_in,
    input  wire logic [2:0]           status_flags_in,
    input  wire logic                 status_flags_we_in,
    input  wire logic                 pc_load_in,
    output logic [7:0]                rdata_out,
    output logic                      rvalid_out,
    output sfrb_pkg::sfrb_ports_t     latch_out,
    output logic [4:0]                pc_upper_out,
    output logic                      pcl_we_out,
    output logic [7:0]                pcl_wdata_out,
    output logic                      indirect_we_out,
    output logic [8:0]                indirect_addr_out,
    output logic [7:0]                indirect_wdata_out,
    output logic                      tx_load_out,
    output logic [7:0]                bank_select_out
);

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic [1:0]            rst_sync_reg;
    logic                  rst_n;
    sfrb_pkg::sfrb_ports_t pins_s1_reg;
    sfrb_pkg::sfrb_ports_t pins_s2_reg;
    logic [1:0]            por_sync_reg;
    logic [1:0]            oth_sync_reg;

    // Two-stage release keeps deassertion synchronous to mclk_in
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pins and reset-cause levels come from outside the clock domain
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_reg  <= '0;
            pins_s2_reg  <= '0;
            por_sync_reg <= 2'h0;
            oth_sync_reg <= 2'h0;
        end else begin
            pins_s1_reg  <= pins_in;
            pins_s2_reg  <= pins_s1_reg;
            por_sync_reg <= {por_sync_reg[0], por_in};
            oth_sync_reg <= {oth_sync_reg[0], other_rst_in};
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    logic       hit;
    logic [6:0] off;
    logic       wr;
    logic       rd;

    sfrb_decode u_decode (
        .addr_in (acc_in.addr),
        .hit_out (hit),
        .off_out (off)
    );
    assign wr = acc_in.wr && hit;
    assign rd = acc_in.rd;

    // ****************************************
    // Register storage, indexed by offset
    // ****************************************
    logic [7:0] regs_reg  [0:29];
    logic [7:0] regs_next [0:29];
    logic [7:0] rdata_reg, rdata_next;
    logic       rvalid_reg, rvalid_next;
    logic       pcl_we_reg, pcl_we_next;
    logic       ind_we_reg, ind_we_next;
    logic       tx_reg, tx_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [4:0] pcu_reg, pcu_next;

    // Implemented-bit mask per offset; unimplemented bits store and read zero
    function automatic logic [7:0] bit_mask(input logic [6:0] o);
        case (o)
            `SFRB_OFF_PORT_A:  bit_mask = `SFRB_MASK_PORT_A;
            `SFRB_OFF_PORT_E:  bit_mask = `SFRB_MASK_PORT_E;
            `SFRB_OFF_PCUPPER: bit_mask = `SFRB_MASK_PCUPPER;
            `SFRB_OFF_PFLAGS1: bit_mask = `SFRB_MASK_PFLAGS1;
            `SFRB_OFF_PFLAGS2: bit_mask = `SFRB_MASK_PFLAGS2;
            `SFRB_OFF_T1CTL:   bit_mask = `SFRB_MASK_T1CTL;
            `SFRB_OFF_T2CTL:   bit_mask = `SFRB_MASK_T2CTL;
            `SFRB_OFF_CCP1CTL: bit_mask = `SFRB_MASK_CCPCTL;
            `SFRB_OFF_CCP2CTL: bit_mask = `SFRB_MASK_CCPCTL;
            `SFRB_OFF_RXSTAT:  bit_mask = `SFRB_MASK_RXSTAT;
            default:           bit_mask = 8'hFF;
        endcase
    endfunction

    // Registers cleared by every reset; power-on clears the rest except status 4:3, pin or watchdog reset keeps them except status 7:5, INTCTL 7:1, RXSTAT 7:1
    function automatic logic clr_any(input logic [6:0] o);
        case (o)
            `SFRB_OFF_PFLAGS1, `SFRB_OFF_PFLAGS2, `SFRB_OFF_TIMER_TWO_COUNT,
            `SFRB_OFF_T2CTL, `SFRB_OFF_SSCTL, `SFRB_OFF_CCP1CTL,
            `SFRB_OFF_CCP2CTL, `SFRB_OFF_TXDATA, `SFRB_OFF_RXDATA,
            `SFRB_OFF_PCUPPER: clr_any = 1'b1;
            default:           clr_any = 1'b0;
        endcase
    endfunction

    // Next state: writes, port latches, resets by cause
    always_comb begin
        logic [7:0] st;
        st = `SFRB_RST_ZERO;
        for (int i = 0; i < 30; i++) begin
            regs_next[i] = regs_reg[i];
        end
        pcl_we_next = 1'b0;
        ind_we_next = 1'b0;
        tx_next     = 1'b0;
        wdata_next  = acc_in.wdata;
        pcu_next    = pcu_reg;
        if (wr) begin
            case (off)
                `SFRB_OFF_INDIRECT: ind_we_next = 1'b1;
                `SFRB_OFF_PCL:      pcl_we_next = 1'b1;
                `SFRB_OFF_RXDATA:   ;       // Read-only, write ignored
                `SFRB_OFF_TXDATA: begin
                    regs_next[off[4:0]] = acc_in.wdata;
                    tx_next             = 1'b1;
                end
                `SFRB_OFF_STATUS: begin
                    // Timeout and power-down are not software-writable
                    st = regs_reg[3];
                    regs_next[3] = {acc_in.wdata[7:5], st[4:3], acc_in.wdata[2:0]};
                end
                default: begin
                    regs_next[off[4:0]] = acc_in.wdata & bit_mask(off);
                end
            endcase
        end
        if (status_flags_we_in) begin
            regs_next[3][2:0] = status_flags_in;
        end
        // Buffer moves into PC 12:8 on a core jump or PROGRAM_COUNTER_LOW write
        if (pc_load_in || pcl_we_next) begin
            pcu_next = regs_next[10][4:0];
        end
        if (por_sync_reg[1]) begin
            // Power-on or brown-out: documented clears, unknowns taken as zero
            for (int i = 0; i < 30; i++) begin
                regs_next[i] = `SFRB_RST_UNKNOWN;
            end
            regs_next[3] = {3'h0, `SFRB_ST_TOPD_POR, 3'h0};
            pcu_next     = 5'h00;
        end else if (oth_sync_reg[1]) begin
            // Pin or watchdog: listed registers clear, as do status 7:5, INTCTL 7:1 and RXSTAT 7:1; others hold
            for (int i = 0; i < 30; i++) begin
                if (clr_any(7'(i))) begin
                    regs_next[i] = `SFRB_RST_ZERO;
                end
            end
            regs_next[3][7:5] = 3'h0;
            regs_next[11][7:1] = 7'h00;
            regs_next[24] = {4'h0, 1'b0, 2'h0, regs_reg[24][0]};
            pcu_next      = 5'h00;
        end
        rvalid_next = rd;
        rdata_next  = `SFRB_RST_ZERO;
        if (rd && hit) begin
            case (off)
                `SFRB_OFF_INDIRECT: rdata_next = indirect_rdata_in[7:0];
                `SFRB_OFF_PCL:      rdata_next = pc_low_in;
                `SFRB_OFF_TXDATA:   rdata_next = `SFRB_RST_ZERO;
                `SFRB_OFF_PORT_A:   rdata_next = pins_s2_reg.a & `SFRB_MASK_PORT_A;
                `SFRB_OFF_PORT_B:   rdata_next = pins_s2_reg.b;
                `SFRB_OFF_PORT_C:   rdata_next = pins_s2_reg.c;
                `SFRB_OFF_PORT_D:   rdata_next = pins_s2_reg.d;
                `SFRB_OFF_PORT_E:   rdata_next = pins_s2_reg.e & `SFRB_MASK_PORT_E;
                default:            rdata_next = regs_reg[off[4:0]] & bit_mask(off);
            endcase
        end
    end

    // Register update only
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 30; i++) begin
                regs_reg[i] <= `SFRB_RST_ZERO;
            end
            rdata_reg  <= `SFRB_RST_ZERO;
            rvalid_reg <= 1'b0;
            pcl_we_reg <= 1'b0;
            ind_we_reg <= 1'b0;
            tx_reg     <= 1'b0;
            wdata_reg  <= `SFRB_RST_ZERO;
            pcu_reg    <= 5'h00;
        end else begin
            for (int i = 0; i < 30; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            pcl_we_reg <= pcl_we_next;
            ind_we_reg <= ind_we_next;
            tx_reg     <= tx_next;
            wdata_reg  <= wdata_next;
            pcu_reg    <= pcu_next;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    assign rdata_out          = rdata_reg;
    assign rvalid_out         = rvalid_reg;
    assign latch_out          = '{a: regs_reg[5], b: regs_reg[6], c: regs_reg[7],
                                  d: regs_reg[8], e: regs_reg[9]};
    assign pc_upper_out       = pcu_reg;
    assign pcl_we_out         = pcl_we_reg;
    assign pcl_wdata_out      = wdata_reg;
    assign indirect_we_out    = ind_we_reg;
    // Indirect reach uses pointer plus indirect bank bit, kept clear by software
    assign indirect_addr_out  = {regs_reg[3][`SFRB_ST_IRP], regs_reg[4]};
    assign indirect_wdata_out = wdata_reg;
    assign tx_load_out        = tx_reg;
    assign bank_select_out    = regs_reg[3];

endmodule

// [sfrb_bank_bench.sv]
// Self-checking bench for the bank-zero register map
`timescale 1ns/100ps
module sfrb_bank_bench;
    logic                   mclk_in = 1'b0;
    logic                   rstn_in = 1'b0;
    logic                   por_in = 1'b0;
    logic                   oth_in = 1'b0;
    logic                   pc_load = 1'b0;
    logic [2:0]             sflags = 3'h0;
    logic                   sflags_we = 1'b0;
    logic                   tx_load;
    logic [8:0]             ind_addr;
    logic [7:0]             ind_wdata;
    sfrb_pkg::sfrb_access_t acc_in = '0;
    sfrb_pkg::sfrb_ports_t  pins_in = '0;
    sfrb_pkg::sfrb_ports_t  latch_out;
    logic [8:0]             ind_rd = 9'h000;
    logic [7:0]             pc_low = 8'h00;
    logic [7:0]             rdata_out;
    logic                   rvalid_out;
    logic [4:0]             pc_upper_out;
    logic [7:0]             mdl [0:31];
    logic [31:0]            seed = 32'h9711;
    int                     num_errors = 0;
    int                     check_count = 0;
    int                     cycles = 0;

    // ****************************************
    // Design, clock and run limit
    // ****************************************
    sfrb_bank DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .por_in(por_in),
        .other_rst_in(oth_in), .acc_in(acc_in), .pins_in(pins_in),
        .indirect_rdata_in(ind_rd), .pc_low_in(pc_low), .status_flags_in(sflags),
        .status_flags_we_in(sflags_we), .pc_load_in(pc_load), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .latch_out(latch_out), .pc_upper_out(pc_upper_out),
        .pcl_we_out(), .pcl_wdata_out(), .indirect_we_out(), .indirect_addr_out(ind_addr),
        .indirect_wdata_out(ind_wdata), .tx_load_out(tx_load), .bank_select_out());

    always #10 mclk_in = ~mclk_in;

    // Whole run needs under a thousand cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Read-back model: pins for ports, masks for partly built registers
    function automatic logic [7:0] expv(input int off);
        case (off)
            0: return ind_rd[7:0];
            2: return pc_low;
            5: return pins_in.a & 8'h3F;
            6: return pins_in.b;
            7: return pins_in.c;
            8: return pins_in.d;
            9: return pins_in.e & 8'h07;
            10: return mdl[off] & 8'h1F;
            12: return mdl[off] & 8'hBF;
            13: return mdl[off] & 8'h01;
            16, 23, 29: return mdl[off] & 8'h3F;
            18: return mdl[off] & 8'h7F;
            24: return mdl[off] & 8'hF7;
            25, 26, 30, 31: return 8'h00;
            default: return mdl[off];
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        acc_in <= '{1'b0, 1'b1, a, d};
        @(negedge mclk_in);
        acc_in <= '0;
    endtask

    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge mclk_in);
        acc_in <= '{1'b1, 1'b0, a, 8'h00};
        @(negedge mclk_in);
        acc_in <= '0;
        chk("rvalid", {7'h00, rvalid_out}, 8'h01);
        d = rdata_out;
    endtask

    task automatic rd_all();
        logic [7:0] d;
        for (int i = 0; i < 32; i++) begin
            rd(i[8:0], d);
            chk("rdata", d, expv(i));
        end
    endtask

    // Reset cause held long enough to pass its synchroniser
    task automatic pulse(input bit pwr);
        @(negedge mclk_in);
        if (pwr) por_in = 1'b1;
        else oth_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        por_in = 1'b0;
        oth_in = 1'b0;
        repeat (6) @(negedge mclk_in);
        if (pwr) begin
            foreach (mdl[i]) mdl[i] = 8'h00;
            mdl[3] = 8'h18;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0]  d;
        logic [63:0] r;
        r = {rnd(), rnd()};
        pins_in = r[39:0];
        ind_rd = r[48:40];
        pc_low = r[63:56];
        repeat (4) @(negedge mclk_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        pulse(1'b1);
        rd_all();
        chk("latch_b", latch_out.b, 8'h00);
        wr(9'h003, 8'h27); // bank bits 7:6 kept clear
        mdl[3] = 8'h3F;
        for (int i = 0; i < 32; i++) begin
            if (i != 3) begin
                r = {32'h0, rnd()};
                d = r[7:0];
                if (i == 12) d[6] = 1'b0; // reserved flag kept clear
                wr(i[8:0], d);
                mdl[i] = d;
            end
        end
        chk("latch_b", latch_out.b, mdl[6]);
        rd_all();
        // Transmit write pulses its load strobe; indirect write forwards pointer and data
        wr(9'h019, 8'hA5);
        chk("tx_load", {7'h00, tx_load}, 8'h01);
        wr(9'h100, 8'h3C);
        chk("ind_wdata", ind_wdata, 8'h3C);
        chk("ind_addr", ind_addr[7:0], mdl[4]);
        chk("ind_bank", {7'h00, ind_addr[8]}, {7'h00, mdl[3][7]});
        // Bank one: ports are not common, so the write must be dropped
        wr(9'h085, ~mdl[5]);
        chk("latch_a", latch_out.a & 8'h3F, mdl[5] & 8'h3F);
        rd(9'h085, d);
        chk("bank1", d, 8'h00);
        wr(9'h08A, 8'h15);
        mdl[10] = 8'h15;
        @(negedge mclk_in);
        pc_load = 1'b1;
        @(negedge mclk_in);
        pc_load = 1'b0;
        chk("pc_upper", {3'h0, pc_upper_out}, 8'h15);
        rd(9'h10A, d);
        chk("pcu_common", d, 8'h15);
        // Core status flag update, seen on the next status read
        @(negedge mclk_in);
        sflags = 3'h5;
        sflags_we = 1'b1;
        @(negedge mclk_in);
        sflags_we = 1'b0;
        mdl[3] = {mdl[3][7:3], 3'h5};
        rd(9'h003, d);
        chk("status_flags", d, mdl[3]);
        // Brown-out flag lives outside this bank, so nothing here must keep it set
        pulse(1'b0);
        foreach (mdl[i]) if (i inside {10, 12, 13, 17, 18, 20, 23, 25, 26, 29}) mdl[i] = 8'h00;
        mdl[11] &= 8'h01;
        mdl[24] &= 8'h01;
        mdl[3] &= 8'h1F;
        rd_all();
        chk("latch_b", latch_out.b, mdl[6]);
        pulse(1'b1);
        rd_all();
        chk("latch_b", latch_out.b, 8'h00);
        conclude();
    end
endmodule

// [sfrb_bank_checker.sv]
// Concurrent checks on the ports of the bank-zero register map
`timescale 1ns/100ps
module sfrb_bank_checker (
    input  wire logic                   mclk_in,
    input  wire logic                   rstn_in,
    input  wire sfrb_pkg::sfrb_access_t acc_in,
    input  wire logic                   pc_load_in,
    input  wire logic                   status_flags_we_in,
    input  wire logic [7:0]             rdata_out,
    input  wire logic                   rvalid_out,
    input  wire sfrb_pkg::sfrb_ports_t  latch_out,
    input  wire logic [4:0]             pc_upper_out,
    input  wire logic                   pcl_we_out,
    input  wire logic [7:0]             pcl_wdata_out,
    input  wire logic                   indirect_we_out,
    input  wire logic [7:0]             bank_select_out
);
    // ****************************************
    // Port relations
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_read_answers: assert property (acc_in.rd |=> rvalid_out)
        else $error("read not answered next cycle");
    a_no_stray_valid: assert property (!acc_in.rd |=> !rvalid_out)
        else $error("read valid without a read");
    a_gap_reads_zero: assert property (acc_in.rd && acc_in.addr[6:0] >= 7'h1E |=> rdata_out == 8'h00)
        else $error("unimplemented offset read not zero");
    a_bank_one_zero: assert property (acc_in.rd && acc_in.addr == 9'h085 |=> rdata_out == 8'h00)
        else $error("bank one non-common offset read not zero");
    a_pc_low_write: assert property (acc_in.wr && acc_in.addr[6:0] == 7'h02 |=> pcl_we_out && pcl_wdata_out == $past(acc_in.wdata))
        else $error("program counter low write not passed on");
    a_pcu_transfer: assert property ((acc_in.wr && acc_in.addr[6:0] == 7'h0A) ##1 !acc_in.wr ##1 pc_load_in |=> pc_upper_out == $past(acc_in.wdata[4:0], 3))
        else $error("upper buffer not moved into program counter");
    a_port_latch: assert property (acc_in.wr && acc_in.addr == 9'h006 |=> latch_out.b == $past(acc_in.wdata))
        else $error("port write did not load latch");
    a_status_common: assert property (acc_in.wr && acc_in.addr[6:0] == 7'h03 && !status_flags_we_in |=> bank_select_out[7:5] == $past(acc_in.wdata[7:5]))
        else $error("status bank bits not written");
    a_indirect_write: assert property (acc_in.wr && acc_in.addr[6:0] == 7'h00 |=> indirect_we_out)
        else $error("indirect write not forwarded");
endmodule

bind sfrb_bank sfrb_bank_checker u_chk (.mclk_in(mclk_in), .rstn_in(rstn_in), .acc_in(acc_in),
    .pc_load_in(pc_load_in), .status_flags_we_in(status_flags_we_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .latch_out(latch_out), .pc_upper_out(pc_upper_out),
    .pcl_we_out(pcl_we_out), .pcl_wdata_out(pcl_wdata_out),
    .indirect_we_out(indirect_we_out), .bank_select_out(bank_select_out));

// [sfrb_decode.sv]
// Address decoder: bank-independent common registers and bank-zero window
`timescale 1ns/100ps
`include "sfrb_defs.svh"

module sfrb_decode (
    input  wire logic [8:0] addr_in,
    output logic            hit_out,
    output logic [6:0]      off_out
);

    // Common registers are seen at their offset in every bank
    function automatic logic is_common(input logic [6:0] off);
        is_common = (off == `SFRB_OFF_INDIRECT) || (off == `SFRB_OFF_PCL)
                 || (off == `SFRB_OFF_STATUS) || (off == `SFRB_OFF_POINTER)
                 || (off == `SFRB_OFF_PCUPPER) || (off == `SFRB_OFF_INTCTL);
    endfunction

    // Bank zero holds everything below 0x1E; common ones ignore bank bits
    always_comb begin
        off_out = addr_in[6:0];
        hit_out = is_common(addr_in[6:0])
               || ((addr_in[8:7] == 2'b00) && (addr_in[6:0] <= `SFRB_OFF_CCP2CTL));
    end

endmodule

// [sfrb_defs.svh]
// Offsets, field positions, masks and reset values of the bank-zero register map
`ifndef SFRB_DEFS_SVH
`define SFRB_DEFS_SVH

// ****************************************
// Register offsets within a bank
// ****************************************
`define SFRB_OFF_INDIRECT   7'h00
`define SFRB_OFF_TIMER_ZERO_COUNT       7'h01
`define SFRB_OFF_PCL        7'h02
`define SFRB_OFF_STATUS     7'h03
`define SFRB_OFF_POINTER    7'h04
`define SFRB_OFF_PORT_A     7'h05
`define SFRB_OFF_PORT_B     7'h06
`define SFRB_OFF_PORT_C     7'h07
`define SFRB_OFF_PORT_D     7'h08
`define SFRB_OFF_PORT_E     7'h09
`define SFRB_OFF_PCUPPER    7'h0A
`define SFRB_OFF_INTCTL     7'h0B
`define SFRB_OFF_PFLAGS1    7'h0C
`define SFRB_OFF_PFLAGS2    7'h0D
`define SFRB_OFF_TIMER_ONE_LOW      7'h0E
`define SFRB_OFF_TIMER_ONE_HIGH      7'h0F
`define SFRB_OFF_T1CTL      7'h10
`define SFRB_OFF_TIMER_TWO_COUNT       7'h11
`define SFRB_OFF_T2CTL      7'h12
`define SFRB_OFF_SSBUF      7'h13
`define SFRB_OFF_SSCTL      7'h14
`define SFRB_OFF_CCP1L      7'h15
`define SFRB_OFF_CCP1H      7'h16
`define SFRB_OFF_CCP1CTL    7'h17
`define SFRB_OFF_RXSTAT     7'h18
`define SFRB_OFF_TXDATA     7'h19
`define SFRB_OFF_RXDATA     7'h1A
`define SFRB_OFF_CCP2L      7'h1B
`define SFRB_OFF_CCP2H      7'h1C
`define SFRB_OFF_CCP2CTL    7'h1D

// ****************************************
// Implemented-bit masks
// ****************************************
`define SFRB_MASK_PORT_A    8'h3F
`define SFRB_MASK_PORT_E    8'h07
`define SFRB_MASK_PCUPPER   8'h1F
`define SFRB_MASK_PFLAGS1   8'hBF
`define SFRB_MASK_PFLAGS2   8'h01
`define SFRB_MASK_T1CTL     8'h3F
`define SFRB_MASK_T2CTL     8'h7F
`define SFRB_MASK_CCPCTL    8'h3F
`define SFRB_MASK_RXSTAT    8'hF7

// ****************************************
// Status fields
// ****************************************
`define SFRB_ST_IRP         7
`define SFRB_ST_RP1         6
`define SFRB_ST_RP0         5
`define SFRB_ST_TO          4
`define SFRB_ST_PD          3
// Timeout/power-down pair after power-on
`define SFRB_ST_TOPD_POR    2'h3

// ****************************************
// Reset values
// ****************************************
`define SFRB_RST_ZERO       8'h00
`define SFRB_RST_UNKNOWN    8'h00

`endif

// [sfrb_pkg.sv]
// Types shared by the bank-zero register map
package sfrb_pkg;

    // Data-memory access from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [8:0] addr;
        logic [7:0] wdata;
    } sfrb_access_t;

    // Kind of reset in effect
    typedef enum logic [1:0] {
        SFRB_RST_NONE,
        SFRB_RST_POWER,
        SFRB_RST_OTHER
    } sfrb_rst_kind_t;

    // Port latch and pin views
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
    } sfrb_ports_t;

endpackage
